// [rtl/rtcm_mirror.sv]
// Calendar clock mirror: register file, readout, set, adjust and interrupt
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ps
module rtcm_mirror #(
    parameter int SCAN_CYCLES = rtcm_pkg::SCAN_CYC
) (
    input  wire logic                            clk_in,          // 250 MHz clock
    input  wire logic                            rst_b_in,        // Async reset, low
    input  wire logic [rtcm_pkg::ADDR_W-1:0]     addr_in,         // Register index
    input  wire logic [rtcm_pkg::REG_W-1:0]      wdata_in,        // Write data
    input  wire logic                            wr_in,           // Write strobe
    input  wire logic                            rd_in,           // Read strobe
    output logic      [rtcm_pkg::REG_W-1:0]      rdata_out,       // Read data, next cycle
    output logic                                 irq_out,         // Level interrupt
    input  wire logic [rtcm_pkg::TIME_W-1:0]     chip_time_in,    // Time from clock chip
    input  wire logic                            chip_present_in, // Clock chip fitted
    output logic      [rtcm_pkg::TIME_W-1:0]     chip_time_out,   // Time to clock chip
    output logic                                 chip_load_out    // Load pulse to chip
);
    localparam int CNT_W = $clog2(SCAN_CYCLES + 1);
    localparam int SYN_W = rtcm_pkg::TIME_W + 1;

    typedef struct packed {
        logic [rtcm_pkg::NUM_MIR-1:0][rtcm_pkg::REG_W-1:0] mir;
        logic                          hold;
        logic                          trig;
        logic                          adj;
        logic                          trig_d;
        logic                          adj_d;
        logic                          err;
        logic [rtcm_pkg::NUM_EV-1:0]   ev_st;
        logic [rtcm_pkg::NUM_EV-1:0]   ev_mask;
        logic                          irq;
        logic [rtcm_pkg::REG_W-1:0]    rdata;
        logic [SYN_W-1:0]              syn1;
        logic [SYN_W-1:0]              syn2;
        logic [SYN_W-1:0]              syn3;
        logic [SYN_W-1:0]              stab;
        logic [CNT_W-1:0]              scan_cnt;
        logic                          load;
        logic [rtcm_pkg::TIME_W-1:0]   load_time;
    } rtcm_state_s;

    rtcm_state_s state_r;
    rtcm_state_s state_nxt;

    function automatic logic [7:0] fld(input logic [rtcm_pkg::TIME_W-1:0] t, input int i);
        fld = t[i*rtcm_pkg::FLD_W +: rtcm_pkg::FLD_W];
    endfunction

    function automatic logic [7:0] days_in_month(input logic [7:0] mon, input logic [7:0] yr);
        if (mon == rtcm_pkg::FEB) begin
            days_in_month = (yr[1:0] == 2'h0) ? rtcm_pkg::DAYS_29 : rtcm_pkg::DAYS_28;
        end else if (rtcm_pkg::SHORT_MONS[4'(mon - 8'h01)]) begin
            days_in_month = rtcm_pkg::DAYS_30;
        end else begin
            days_in_month = rtcm_pkg::DAYS_31;
        end
    endfunction

    // Range check of every field before a set value is sent to the chip
    function automatic logic time_legal(input logic [rtcm_pkg::TIME_W-1:0] t);
        logic [7:0] mon;
        logic [7:0] day;
        mon = fld(t, rtcm_pkg::F_MON);
        day = fld(t, rtcm_pkg::F_DAY);
        time_legal = (fld(t, rtcm_pkg::F_SEC) < rtcm_pkg::SEC_LIM)
                   && (fld(t, rtcm_pkg::F_MIN) < rtcm_pkg::MIN_LIM)
                   && (fld(t, rtcm_pkg::F_HOUR) < rtcm_pkg::HOUR_LIM)
                   && (fld(t, rtcm_pkg::F_YEAR) < rtcm_pkg::YEAR_LIM)
                   && (fld(t, rtcm_pkg::F_WEEK) < rtcm_pkg::WEEK_LIM)
                   && (mon != 8'h00) && (mon <= rtcm_pkg::MON_LIM)
                   && (day != 8'h00)
                   && (day <= days_in_month(mon, fld(t, rtcm_pkg::F_YEAR)));
    endfunction

    // Add one minute with full calendar carry
    function automatic logic [rtcm_pkg::TIME_W-1:0] add_minute(
        input logic [rtcm_pkg::TIME_W-1:0] t);
        logic [7:0] mn;
        logic [7:0] hr;
        logic [7:0] dy;
        logic [7:0] mo;
        logic [7:0] yr;
        logic [7:0] wk;
        mn = fld(t, rtcm_pkg::F_MIN) + 8'h01;
        hr = fld(t, rtcm_pkg::F_HOUR);
        dy = fld(t, rtcm_pkg::F_DAY);
        mo = fld(t, rtcm_pkg::F_MON);
        yr = fld(t, rtcm_pkg::F_YEAR);
        wk = fld(t, rtcm_pkg::F_WEEK);
        if (mn >= rtcm_pkg::MIN_LIM) begin                                   // [RL13]
            mn = 8'h00;
            hr = hr + 8'h01;
            if (hr >= rtcm_pkg::HOUR_LIM) begin
                hr = 8'h00;
                dy = dy + 8'h01;
                wk = (wk + 8'h01 >= rtcm_pkg::WEEK_LIM) ? 8'h00 : wk + 8'h01;
                if (dy > days_in_month(mo, yr)) begin
                    dy = 8'h01;
                    mo = mo + 8'h01;
                    if (mo > rtcm_pkg::MON_LIM) begin
                        mo = 8'h01;
                        yr = (yr + 8'h01 >= rtcm_pkg::YEAR_LIM) ? 8'h00 : yr + 8'h01;
                    end
                end
            end
        end
        add_minute = {wk, yr, mo, dy, hr, mn, fld(t, rtcm_pkg::F_SEC)};
    endfunction

    always_comb begin
        logic [rtcm_pkg::TIME_W-1:0] chip_t;
        logic [rtcm_pkg::TIME_W-1:0] mir_t;
        logic [rtcm_pkg::TIME_W-1:0] adj_t;
        logic [rtcm_pkg::NUM_EV-1:0] ev;
        logic                        fitted;
        logic                        scan;
        chip_t = '0;
        mir_t = '0;
        adj_t = '0;
        ev = '0;
        state_nxt = state_r;
        state_nxt.load = 1'b0;

        // Three-stage pin synchroniser; take a value once stages two and three agree
        state_nxt.syn1 = {chip_present_in, chip_time_in};
        state_nxt.syn2 = state_r.syn1;
        state_nxt.syn3 = state_r.syn2;
        if (state_r.syn2 == state_r.syn3) begin
            state_nxt.stab = state_r.syn3;
        end
        chip_t = state_r.stab[rtcm_pkg::TIME_W-1:0];
        fitted = state_r.stab[rtcm_pkg::TIME_W];                              // [RL11]

        scan = (state_r.scan_cnt == CNT_W'(SCAN_CYCLES - 1));
        state_nxt.scan_cnt = scan ? '0 : state_r.scan_cnt + 1'b1;

        for (int i = 0; i < rtcm_pkg::NUM_FLD; i++) begin
            mir_t[i*rtcm_pkg::FLD_W +: rtcm_pkg::FLD_W] =
                state_r.mir[i][rtcm_pkg::FLD_W-1:0];
        end

        // Register writes
        if (wr_in) begin
            if (addr_in < rtcm_pkg::ADDR_W'(rtcm_pkg::NUM_MIR)) begin
                state_nxt.mir[addr_in[2:0]] = wdata_in;                       // [RL1]
            end else if (addr_in == rtcm_pkg::A_CTRL) begin
                state_nxt.hold = wdata_in[rtcm_pkg::C_HOLD];
                state_nxt.trig = wdata_in[rtcm_pkg::C_TRIG];
                state_nxt.adj  = wdata_in[rtcm_pkg::C_ADJ];
            end else if (addr_in == rtcm_pkg::A_IRQ_MASK) begin
                state_nxt.ev_mask = wdata_in[rtcm_pkg::NUM_EV-1:0];
            end
        end

        // Readout overrides a software write to a mirror in the same cycle
        if (scan && !state_r.hold && fitted) begin                            // [RL5] [RL6]
            for (int i = 0; i < rtcm_pkg::NUM_FLD; i++) begin
                state_nxt.mir[i] = {8'h00, fld(chip_t, i)};                   // [RL2] [RL3]
            end
            state_nxt.mir[rtcm_pkg::MIR_PACKED] =                             // [RL4]
                {fld(chip_t, rtcm_pkg::F_HOUR), fld(chip_t, rtcm_pkg::F_MIN)};
        end

        // Set on falling edge of trigger; adjust on rising edge, set has priority
        state_nxt.trig_d = state_r.trig;
        state_nxt.adj_d = state_r.adj;
        if (state_r.trig_d && !state_r.trig) begin                            // [RL7]
            if (fitted && time_legal(mir_t)) begin
                state_nxt.load = 1'b1;
                state_nxt.load_time = mir_t;
                state_nxt.err = 1'b0;
                ev[rtcm_pkg::E_SET_DONE] = 1'b1;
            end else begin
                state_nxt.err = 1'b1;                                         // [RL12]
                ev[rtcm_pkg::E_SET_ERR] = 1'b1;
            end
        end else if (state_r.adj && !state_r.adj_d && fitted) begin
            if (fld(chip_t, rtcm_pkg::F_SEC) < rtcm_pkg::SEC_HALF) begin
                adj_t = chip_t;                                               // [RL9]
            end else begin
                adj_t = add_minute(chip_t);                                   // [RL10]
            end
            adj_t[rtcm_pkg::FLD_W-1:0] = 8'h00;
            state_nxt.load = 1'b1;
            state_nxt.load_time = adj_t;
            ev[rtcm_pkg::E_ADJ_DONE] = 1'b1;
        end

        // Sticky events: write one clears, a new event in the same cycle wins
        if (wr_in && addr_in == rtcm_pkg::A_IRQ_ST) begin
            state_nxt.ev_st = state_r.ev_st & ~wdata_in[rtcm_pkg::NUM_EV-1:0];
        end
        state_nxt.ev_st = state_nxt.ev_st | ev;
        state_nxt.irq = |(state_nxt.ev_st & state_nxt.ev_mask);

        // Read data stands only in the cycle after the strobe
        state_nxt.rdata = '0;
        if (rd_in) begin
            if (addr_in < rtcm_pkg::ADDR_W'(rtcm_pkg::NUM_MIR)) begin
                state_nxt.rdata = state_r.mir[addr_in[2:0]];                  // [RL1]
            end else if (addr_in == rtcm_pkg::A_CTRL) begin
                state_nxt.rdata[rtcm_pkg::C_HOLD] = state_r.hold;
                state_nxt.rdata[rtcm_pkg::C_TRIG] = state_r.trig;
                state_nxt.rdata[rtcm_pkg::C_ADJ]  = state_r.adj;
            end else if (addr_in == rtcm_pkg::A_STAT) begin
                state_nxt.rdata[rtcm_pkg::S_FITTED] = fitted;                 // [RL11]
                state_nxt.rdata[rtcm_pkg::S_ERR]    = state_r.err;            // [RL12]
            end else if (addr_in == rtcm_pkg::A_IRQ_ST) begin
                state_nxt.rdata[rtcm_pkg::NUM_EV-1:0] = state_r.ev_st;
            end else if (addr_in == rtcm_pkg::A_IRQ_MASK) begin
                state_nxt.rdata[rtcm_pkg::NUM_EV-1:0] = state_r.ev_mask;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign rdata_out     = state_r.rdata;
    assign irq_out       = state_r.irq;
    assign chip_time_out = state_r.load_time;
    assign chip_load_out = state_r.load;
endmodule

// [rtl/rtcm_pkg.sv]
// Constants, register map and field layout for the calendar clock mirror
// Contract
// RL1 - Eight consecutive read/write clock mirror registers
// RL2 - First seven mirrors hold seven time kinds
// RL3 - Mirror 0 seconds, 1 minutes, 2 hours
// RL4 - Mirror 7: hour high byte, minute low
// RL5 - Hold clear: copy chip time every scan; the code copies only while the chip is fitted
// RL6 - Hold set: suspend copy, keep written values
// RL7 - Set trigger falling edge loads chip once
// RL8 - Software sets hold before loading set values
// RL9 - Adjust rise, seconds 0-29: clear seconds
// RL10 - Adjust rise, seconds 30-59: clear, add minute
// RL11 - Fitted flag follows clock chip presence
// RL12 - Illegal set value: raise error, skip set
// RL13 - Minute carry ripples through calendar fields
package rtcm_pkg;
    localparam int          FLD_W       = 8;
    localparam int          NUM_FLD     = 7;
    localparam int          TIME_W      = FLD_W * NUM_FLD;
    localparam int          REG_W       = 16;
    localparam int          ADDR_W      = 4;
    localparam int          NUM_MIR     = 8;
    localparam int          NUM_EV      = 3;
    // Field order inside the time vector and mirror index of each field
    localparam int          F_SEC       = 0;
    localparam int          F_MIN       = 1;
    localparam int          F_HOUR      = 2;
    localparam int          F_DAY       = 3;
    localparam int          F_MON       = 4;
    localparam int          F_YEAR      = 5;
    localparam int          F_WEEK      = 6;
    localparam int          MIR_PACKED  = 7;
    // Register indices
    localparam logic [3:0]  A_CTRL      = 4'h8;
    localparam logic [3:0]  A_STAT      = 4'h9;
    localparam logic [3:0]  A_IRQ_ST    = 4'ha;
    localparam logic [3:0]  A_IRQ_MASK  = 4'hb;
    // Control register bits
    localparam int          C_HOLD      = 0;
    localparam int          C_TRIG      = 1;
    localparam int          C_ADJ       = 2;
    // Status register bits
    localparam int          S_FITTED    = 0;
    localparam int          S_ERR       = 1;
    // Event bits
    localparam int          E_SET_DONE  = 0;
    localparam int          E_ADJ_DONE  = 1;
    localparam int          E_SET_ERR   = 2;
    // Calendar limits
    localparam logic [7:0]  SEC_HALF    = 8'h1e;
    localparam logic [7:0]  SEC_LIM     = 8'h3c;
    localparam logic [7:0]  MIN_LIM     = 8'h3c;
    localparam logic [7:0]  HOUR_LIM    = 8'h18;
    localparam logic [7:0]  MON_LIM     = 8'h0c;
    localparam logic [7:0]  YEAR_LIM    = 8'h64;
    localparam logic [7:0]  WEEK_LIM    = 8'h07;
    localparam logic [7:0]  FEB         = 8'h02;
    localparam logic [7:0]  DAYS_31     = 8'h1f;
    localparam logic [7:0]  DAYS_30     = 8'h1e;
    localparam logic [7:0]  DAYS_29     = 8'h1d;
    localparam logic [7:0]  DAYS_28     = 8'h1c;
    // Bit n set: month n+1 has thirty days (April, June, September, November)
    localparam logic [11:0] SHORT_MONS  = 12'h0528;
    // Scan period
    localparam int          CLK_NS      = 4;
    localparam int          SCAN_NS     = 1000;
    localparam int          SCAN_CYC    = SCAN_NS / CLK_NS;
endpackage

// [test/rtcm_chip_model.sv]
// Behavioural calendar clock chip on the far side of the mirror block
`timescale 1ns/1ps
module rtcm_chip_model #(
    parameter logic [55:0] INIT_TIME = 56'h00_0000_0000_0000
) (
    input  wire logic        clk_in,    // Block clock
    input  wire logic        rst_b_in,  // Async reset, low
    input  wire logic        fitted_in, // Chip plugged in
    input  wire logic        load_in,   // Load pulse
    input  wire logic [55:0] time_in,   // Time to store
    output logic      [55:0] time_out   // Chip time lines
);
    logic [55:0] time_r;
    // Time stands still so that every expectation stays exact
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            time_r <= INIT_TIME;
        end else if (load_in && fitted_in) begin
            time_r <= time_in;
        end
    end
    // Absent chip leaves lines floating: show the inverse, not a stale value
    assign time_out = fitted_in ? time_r : ~time_r;
endmodule

// [test/rtcm_mirror_asserts.sv]
// Port-level assertions for the calendar clock mirror
`timescale 1ns/1ps
module rtcm_mirror_asserts (
    input wire logic        clk_in,          // Clock
    input wire logic        rst_b_in,        // Async reset, low
    input wire logic [3:0]  addr_in,         // Register index
    input wire logic [15:0] wdata_in,        // Write data
    input wire logic        wr_in,           // Write strobe
    input wire logic        rd_in,           // Read strobe
    input wire logic [15:0] rdata_out,       // Read data
    input wire logic        irq_out,         // Interrupt
    input wire logic        chip_present_in, // Chip fitted
    input wire logic [55:0] chip_time_out,   // Time to chip
    input wire logic        chip_load_out    // Load pulse
);
    logic [2:0] ctl_r;
    logic       ctl_wr;
    logic       set_ev;
    logic       adj_ev;
    assign ctl_wr = wr_in && addr_in == rtcm_pkg::A_CTRL;
    assign set_ev = ctl_wr && ctl_r[1] && !wdata_in[1];
    // Set beats adjust when both edges land together
    assign adj_ev = ctl_wr && !ctl_r[2] && wdata_in[2] && !set_ev;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctl_r <= 3'h0;
        end else if (ctl_wr) begin
            ctl_r <= wdata_in[2:0];
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
        else $error("read data not zero outside read slot");
    a_load_single: assert property (chip_load_out |=> !chip_load_out)
        else $error("load pulse longer than one cycle");
    a_load_cause: assert property (chip_load_out |-> $past(ctl_wr, 2))
        else $error("load without control write");
    a_time_hold: assert property (!chip_load_out |-> $stable(chip_time_out))
        else $error("chip time changed without load");
    a_adj_sec_clear: assert property (
        adj_ev && chip_present_in && $past(chip_present_in, 8)
        |-> ##2 chip_load_out && chip_time_out[7:0] == 8'h00)
        else $error("adjust did not load cleared seconds");
    a_set_absent: assert property (
        set_ev && !chip_present_in && !$past(chip_present_in, 8) |-> ##1 !chip_load_out [*4])
        else $error("set loaded an absent chip");
    a_fitted_read: assert property (
        rd_in && addr_in == rtcm_pkg::A_STAT && chip_present_in == $past(chip_present_in, 8)
        |=> rdata_out[0] == $past(chip_present_in))
        else $error("fitted flag does not follow chip presence");
    a_irq_masked: assert property (
        wr_in && addr_in == rtcm_pkg::A_IRQ_MASK && wdata_in == 16'h0000 |=> ##1 !irq_out)
        else $error("interrupt high with all events masked");
    c_set_load: cover property (set_ev ##2 chip_load_out);
    c_adj_load: cover property (adj_ev ##2 chip_load_out);
    c_irq_rise: cover property ($rose(irq_out));
endmodule

// [test/rtcm_mirror_tb.sv]
// Self-checking bench for the calendar clock mirror
`timescale 1ns/1ps
module rtcm_mirror_tb;
    localparam logic [55:0] T0 = 56'h03_1802_1c17_3b28; // Feb 28th leap year, 23:59:40
    localparam logic [55:0] T1 = 56'h06_1802_1d17_3b2d; // Feb 29th, 23:59:45
    localparam logic [55:0] T2 = 56'h00_1803_0100_0000; // Carry into Mar 1st
    localparam logic [3:0]  CT = rtcm_pkg::A_CTRL;
    logic        clk_in, rst_b_in, wr_in, rd_in, irq_out, pres, load;
    logic [3:0]  addr_in;
    logic [15:0] wdata_in;
    logic [15:0] rdata_out;
    logic [55:0] t_chip;
    logic [55:0] t_out;
    int          n_fail = 0;
    int          samples_checked = 0;
    rtcm_mirror #(.SCAN_CYCLES(8)) i_rtcm_mirror (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out),
        .chip_time_in(t_chip), .chip_present_in(pres), .chip_time_out(t_out),
        .chip_load_out(load));
    rtcm_chip_model #(.INIT_TIME(T0)) i_rtcm_chip_model (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .fitted_in(pres), .load_in(load),
        .time_in(t_out), .time_out(t_chip));
    task automatic chk(input string nm, input logic [55:0] e, input logic [55:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 chk($sformatf("reg %0d", a), {40'h0, e}, {40'h0, rdata_out});
    endtask
    task automatic ichk(input logic v);
        repeat (2) @(posedge clk_in);
        #1 chk("irq", {55'h0, v}, {55'h0, irq_out});
    endtask
    // Load must show within a bounded window when wanted and stay absent when not; either miss counts as a mismatch
    task automatic load_chk(input logic want, input logic [55:0] e);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 8 && !hit; i++) begin
            @(posedge clk_in);
            #1 hit = load;
        end
        chk("chip_load", {55'h0, want}, {55'h0, hit});
        if (want) chk("chip_time", e, t_out);
    endtask
    task automatic t_readout;
        repeat (30) @(posedge clk_in);
        for (int i = 0; i < 7; i++) rchk(i[3:0], {8'h00, T0[8*i +: 8]});
        rchk(4'h7, T0[23:8]);
        rchk(4'hc, 16'h0000);
        rchk(rtcm_pkg::A_STAT, 16'h0001);
    endtask
    task automatic t_set;
        wr(CT, 16'h0001);
        for (int i = 0; i < 7; i++) wr(i[3:0], {8'h00, T1[8*i +: 8]});
        repeat (20) @(posedge clk_in);
        rchk(4'h0, 16'h002d);
        wr(CT, 16'h0003);
        wr(CT, 16'h0001);
        load_chk(1'b1, T1);
        load_chk(1'b0, T1);
        repeat (10) @(posedge clk_in);
        wr(CT, 16'h0005);
        load_chk(1'b1, T2);
        repeat (10) @(posedge clk_in);
        wr(CT, 16'h0001);
        wr(CT, 16'h0005);
        load_chk(1'b1, T2);
    endtask
    task automatic t_err;
        wr(4'h4, 16'h000d);
        wr(CT, 16'h0003);
        wr(CT, 16'h0001);
        load_chk(1'b0, T2);
        rchk(rtcm_pkg::A_STAT, 16'h0003);
        wr(rtcm_pkg::A_IRQ_MASK, 16'h0004);
        ichk(1'b1);
        wr(rtcm_pkg::A_IRQ_MASK, 16'h0000);
        ichk(1'b0);
        wr(rtcm_pkg::A_IRQ_ST, 16'h0004);
        wr(rtcm_pkg::A_IRQ_MASK, 16'h0004);
        ichk(1'b0);
        @(posedge clk_in);
        pres <= 1'b0;
        repeat (10) @(posedge clk_in);
        rchk(rtcm_pkg::A_STAT, 16'h0002);
        wr(CT, 16'h0003);
        wr(CT, 16'h0001);
        load_chk(1'b0, T2);
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    initial begin
        rst_b_in = 1'b0;
        wr_in = 1'b0;
        rd_in = 1'b0;
        addr_in = 4'h0;
        wdata_in = 16'h0000;
        pres = 1'b1;
        repeat (10) @(posedge clk_in);
        rst_b_in <= 1'b1;
        t_readout;
        t_set;
        t_err;
        report_and_stop;
    end
endmodule
bind rtcm_mirror rtcm_mirror_asserts i_rtcm_mirror_asserts (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out),
    .chip_present_in(chip_present_in), .chip_time_out(chip_time_out),
    .chip_load_out(chip_load_out));
